// ### ldh_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_host_port (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic bus_select_pin_a_i,
  input wire logic bus_select_pin_b_i,
  input wire logic bus_select_pin_c_i,
  input wire logic cs_n_i,
  input wire logic cmd_data_select_i,
  input wire logic rd_e_i,
  input wire logic wr_rw_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [1:0] data_oe_o,
  input wire logic sdi_i,
  input wire logic sclk_i,
  input wire logic [15:0] status_i,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_two_o,
  output logic [11:0] mem_pix0_o,
  output logic [11:0] mem_pix1_o,
  output logic [7:0] cmd_o,
  output logic cmd_valid_o,
  output logic [7:0] param_o,
  output logic param_valid_o,
  output logic sleep_indicator_n_o
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  localparam int SW = 25;
  logic [SW-1:0] pins;
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  assign pins = {bus_select_pin_a_i, bus_select_pin_b_i, bus_select_pin_c_i, cs_n_i,
                 cmd_data_select_i, rd_e_i, wr_rw_i, sdi_i, sclk_i, data_i};

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  logic sel_a_s, sel_b_s, sel_c_s, cs_n_s, cds_s, rd_s, wr_s, sdi_s, sclk_s;
  logic [15:0] data_s;
  assign {sel_a_s, sel_b_s, sel_c_s, cs_n_s, cds_s, rd_s, wr_s, sdi_s, sclk_s, data_s} = sync2_r;

  // --------------------------------------------------------------
  // bus type
  // --------------------------------------------------------------
  ldh_pkg::ldh_bus_t bus_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bus_r <= ldh_pkg::LDH_BUS_NONE;
    end else begin
      bus_r <= ldh_pkg::ldh_bus_decode(sel_a_s, sel_b_s, sel_c_s);
    end
  end

  logic is80, is68, wide, ser_en, nine_bit;
  assign is80 = (bus_r == ldh_pkg::LDH_BUS_80_16) || (bus_r == ldh_pkg::LDH_BUS_80_8);
  assign is68 = (bus_r == ldh_pkg::LDH_BUS_68_16) || (bus_r == ldh_pkg::LDH_BUS_68_8);
  assign wide = (bus_r == ldh_pkg::LDH_BUS_80_16) || (bus_r == ldh_pkg::LDH_BUS_68_16);
  assign ser_en = (bus_r == ldh_pkg::LDH_BUS_SER9) || (bus_r == ldh_pkg::LDH_BUS_SER8);
  assign nine_bit = (bus_r == ldh_pkg::LDH_BUS_SER9);

  // --------------------------------------------------------------
  // parallel strobe edges
  // --------------------------------------------------------------
  logic cs_n_p_r, cds_p_r, rd_p_r, wr_p_r, rd_act_p_r;
  logic [15:0] data_p_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cs_n_p_r <= 1'b1;
      cds_p_r <= 1'b0;
      rd_p_r <= 1'b1;
      wr_p_r <= 1'b1;
      data_p_r <= ldh_pkg::WORD_RST;
    end else begin
      cs_n_p_r <= cs_n_s;
      cds_p_r <= cds_s;
      rd_p_r <= rd_s;
      wr_p_r <= wr_s;
      data_p_r <= data_s;
    end
  end

  logic par_wr_ev, rd_act, rd_start;
  always_comb begin
    par_wr_ev = 1'b0;
    rd_act = 1'b0;
    if (is80) begin
      par_wr_ev = !cs_n_p_r && !wr_p_r && wr_s;
      rd_act = !cs_n_s && !rd_s;
    end else if (is68) begin
      par_wr_ev = !cs_n_p_r && rd_p_r && !rd_s && !wr_p_r;
      rd_act = !cs_n_s && rd_s && wr_s;
    end
  end
  assign rd_start = rd_act && !rd_act_p_r;

  // --------------------------------------------------------------
  // serial receiver
  // --------------------------------------------------------------
  ldh_byte_if ser_byte ();

  ldh_serial_rx u_serial (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .ser_en_i(ser_en),
    .nine_bit_i(nine_bit),
    .cs_n_i(cs_n_s),
    .sclk_i(sclk_s),
    .sdi_i(sdi_s),
    .cds_i(cds_s),
    .byte_o(ser_byte)
  );

  // --------------------------------------------------------------
  // unified write event
  // --------------------------------------------------------------
  logic wr_ev, wr_is_data, wr_wide;
  logic [15:0] wr_word;
  always_comb begin
    wr_ev = 1'b0;
    wr_is_data = 1'b0;
    wr_wide = 1'b0;
    wr_word = ldh_pkg::WORD_RST;
    if (ser_en && ser_byte.valid) begin
      wr_ev = 1'b1;
      wr_is_data = ser_byte.is_data;
      wr_word = {8'h00, ser_byte.data};
    end else if (par_wr_ev) begin
      wr_ev = 1'b1;
      wr_is_data = cds_p_r;
      wr_wide = wide;
      wr_word = wide ? data_p_r : {8'h00, data_p_r[7:0]};
    end
  end

  // --------------------------------------------------------------
  // command and parameter tracking
  // --------------------------------------------------------------
  logic [7:0] cur_cmd_r;
  logic [4:0] par_idx_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cur_cmd_r <= ldh_pkg::CMD_RESET_VAL;
      par_idx_r <= 5'h00;
      cmd_o <= 8'h00;
      cmd_valid_o <= 1'b0;
      param_o <= 8'h00;
      param_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= wr_ev && !wr_is_data;
      param_valid_o <= wr_ev && wr_is_data && cur_cmd_r != ldh_pkg::CMD_MEM_WRITE;
      if (wr_ev && !wr_is_data) begin
        cur_cmd_r <= wr_word[7:0];
        cmd_o <= wr_word[7:0];
        par_idx_r <= 5'h00;
      end else if (wr_ev && cur_cmd_r != ldh_pkg::CMD_MEM_WRITE) begin
        param_o <= wr_word[7:0];
        if (par_idx_r != ldh_pkg::PAR_IDX_MAX) begin
          par_idx_r <= par_idx_r + 5'h01;
        end
      end
    end
  end

  logic par_wr;
  assign par_wr = wr_ev && wr_is_data && cur_cmd_r != ldh_pkg::CMD_MEM_WRITE;

  // --------------------------------------------------------------
  // sleep indicator
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sleep_indicator_n_o <= ldh_pkg::SLEEP_N_RST;
    end else if (wr_ev && !wr_is_data && wr_word[7:0] == ldh_pkg::CMD_SLEEP_IN) begin
      sleep_indicator_n_o <= 1'b0;
    end else if (wr_ev && !wr_is_data && wr_word[7:0] == ldh_pkg::CMD_SLEEP_OUT) begin
      sleep_indicator_n_o <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // colour format from data control
  // --------------------------------------------------------------
  ldh_pkg::ldh_color_t color_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      color_r <= ldh_pkg::LDH_COL_256;
    end else if (par_wr && cur_cmd_r == ldh_pkg::CMD_DATA_CTRL && par_idx_r == ldh_pkg::DATCTL_COLOR_IDX) begin
      if (wr_word[2:0] == ldh_pkg::COLOR_CODE_A) begin
        color_r <= ldh_pkg::LDH_COL_A;
      end else if (wr_word[2:0] == ldh_pkg::COLOR_CODE_B) begin
        color_r <= ldh_pkg::LDH_COL_B;
      end else begin
        color_r <= ldh_pkg::LDH_COL_256;
      end
    end
  end

  // --------------------------------------------------------------
  // palette
  // --------------------------------------------------------------
  logic [3:0] pal_r [0:ldh_pkg::PAL_ENTRIES-1];
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < ldh_pkg::PAL_ENTRIES; i++) begin
        pal_r[i] <= ldh_pkg::PAL_RST_VAL;
      end
    end else if (par_wr && cur_cmd_r == ldh_pkg::CMD_PALETTE_SET && par_idx_r < ldh_pkg::PAL_COUNT) begin
      pal_r[par_idx_r] <= wr_word[3:0];
    end
  end

  function automatic logic [11:0] pal_expand(input logic [7:0] b);
    logic [4:0] ig;
    logic [4:0] ib;
    ig = ldh_pkg::PAL_G_BASE + {2'b00, b[4:2]};
    ib = ldh_pkg::PAL_B_BASE + {3'b000, b[1:0]};
    pal_expand = {pal_r[{2'b00, b[7:5]}], pal_r[ig], pal_r[ib]};
  endfunction

  // --------------------------------------------------------------
  // pixel gathering and holding register
  // --------------------------------------------------------------
  typedef enum logic [1:0] {LDH_G0, LDH_G1, LDH_G2} ldh_gath_t;
  ldh_gath_t gath_r;
  logic [7:0] g0_r;
  logic [7:0] g1_r;
  logic pix_wr;
  assign pix_wr = wr_ev && wr_is_data && cur_cmd_r == ldh_pkg::CMD_MEM_WRITE;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gath_r <= LDH_G0;
      g0_r <= 8'h00;
      g1_r <= 8'h00;
      mem_wr_o <= 1'b0;
      mem_two_o <= 1'b0;
      mem_pix0_o <= ldh_pkg::PIX_RST;
      mem_pix1_o <= ldh_pkg::PIX_RST;
    end else begin
      mem_wr_o <= 1'b0;
      if (wr_ev && !wr_is_data) begin
        gath_r <= LDH_G0;
      end else if (pix_wr && wr_wide) begin
        mem_wr_o <= 1'b1;
        mem_two_o <= (color_r == ldh_pkg::LDH_COL_256);
        case (color_r)
          ldh_pkg::LDH_COL_A: mem_pix0_o <= wr_word[15:4];
          ldh_pkg::LDH_COL_B: mem_pix0_o <= wr_word[11:0];
          default: begin
            mem_pix0_o <= pal_expand(wr_word[15:8]);
            mem_pix1_o <= pal_expand(wr_word[7:0]);
          end
        endcase
      end else if (pix_wr) begin
        case (color_r)
          ldh_pkg::LDH_COL_A: begin
            case (gath_r)
              LDH_G0: begin
                g0_r <= wr_word[7:0];
                gath_r <= LDH_G1;
              end
              LDH_G1: begin
                g1_r <= wr_word[7:0];
                gath_r <= LDH_G2;
              end
              default: begin
                mem_pix0_o <= {g0_r, g1_r[7:4]};
                mem_pix1_o <= {g1_r[3:0], wr_word[7:0]};
                mem_two_o <= 1'b1;
                mem_wr_o <= 1'b1;
                gath_r <= LDH_G0;
              end
            endcase
          end
          ldh_pkg::LDH_COL_B: begin
            case (gath_r)
              LDH_G0: begin
                g0_r <= wr_word[7:0];
                gath_r <= LDH_G1;
              end
              default: begin
                mem_pix0_o <= {g0_r[3:0], wr_word[7:0]};
                mem_two_o <= 1'b0;
                mem_wr_o <= 1'b1;
                gath_r <= LDH_G0;
              end
            endcase
          end
          default: begin
            mem_pix0_o <= pal_expand(wr_word[7:0]);
            mem_two_o <= 1'b0;
            mem_wr_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // read path through the holder
  // --------------------------------------------------------------
  logic [15:0] holder_r;
  logic rd_pend_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_act_p_r <= 1'b0;
      data_oe_o <= 2'b00;
      data_o <= ldh_pkg::WORD_RST;
      mem_rd_o <= 1'b0;
      rd_pend_r <= 1'b0;
      holder_r <= ldh_pkg::WORD_RST;
    end else begin
      rd_act_p_r <= rd_act;
      data_oe_o <= rd_act ? {wide, 1'b1} : 2'b00;
      mem_rd_o <= rd_start && cds_s;
      rd_pend_r <= mem_rd_o;
      if (rd_pend_r) begin
        holder_r <= mem_rdata_i;
      end
      if (rd_start) begin
        data_o <= cds_s ? holder_r : status_i;
      end
    end
  end

endmodule
`default_nettype wire

// ### ldh_pkg.sv
`default_nettype none
package ldh_pkg;

  // --------------------------------------------------------------
  // command codes
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_PALETTE_SET = 8'hA0;
  localparam logic [7:0] CMD_MEM_WRITE = 8'hA1;
  localparam logic [7:0] CMD_MEM_READ = 8'hA2;
  localparam logic [7:0] CMD_DATA_CTRL = 8'hA3;
  localparam logic [7:0] CMD_SLEEP_IN = 8'hA4;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'hA5;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;

  // --------------------------------------------------------------
  // parameter layout
  // --------------------------------------------------------------
  localparam int PAL_ENTRIES = 20;
  localparam logic [4:0] PAL_COUNT = 5'h14;
  localparam logic [4:0] PAL_G_BASE = 5'h08;
  localparam logic [4:0] PAL_B_BASE = 5'h10;
  localparam logic [4:0] PAR_IDX_MAX = 5'h1F;
  localparam logic [4:0] DATCTL_COLOR_IDX = 5'h02;
  localparam logic [2:0] COLOR_CODE_A = 3'h2;
  localparam logic [2:0] COLOR_CODE_B = 3'h4;
  localparam logic [3:0] PAL_RST_VAL = 4'h0;

  // --------------------------------------------------------------
  // serial bit counts
  // --------------------------------------------------------------
  localparam logic [3:0] SER_LAST8 = 4'h7;
  localparam logic [3:0] SER_LAST9 = 4'h8;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic SLEEP_N_RST = 1'b1;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [11:0] PIX_RST = 12'h000;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    LDH_BUS_80_16, LDH_BUS_80_8, LDH_BUS_68_16, LDH_BUS_68_8,
    LDH_BUS_SER9, LDH_BUS_SER8, LDH_BUS_NONE
  } ldh_bus_t;

  typedef enum logic [1:0] {LDH_COL_256, LDH_COL_A, LDH_COL_B} ldh_color_t;

  function automatic ldh_bus_t ldh_bus_decode(input logic a, input logic b, input logic c);
    case ({a, b, c})
      3'b111: ldh_bus_decode = LDH_BUS_80_16;
      3'b110: ldh_bus_decode = LDH_BUS_80_8;
      3'b100: ldh_bus_decode = LDH_BUS_68_16;
      3'b011: ldh_bus_decode = LDH_BUS_68_8;
      3'b001: ldh_bus_decode = LDH_BUS_SER9;
      3'b000: ldh_bus_decode = LDH_BUS_SER8;
      default: ldh_bus_decode = LDH_BUS_NONE;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### ldh_byte_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ldh_byte_if;
  logic valid;
  logic is_data;
  logic [7:0] data;
  modport tx (output valid, output is_data, output data);
  modport rx (input valid, input is_data, input data);
endinterface
`default_nettype wire

// ### ldh_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_serial_rx (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ser_en_i,
  input wire logic nine_bit_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic cds_i,
  ldh_byte_if.tx byte_o
);

  logic sclk_p_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic flag_r;
  logic sclk_rise;
  logic [3:0] last;

  assign sclk_rise = sclk_i & ~sclk_p_r;
  assign last = nine_bit_i ? ldh_pkg::SER_LAST9 : ldh_pkg::SER_LAST8;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sclk_p_r <= 1'b0;
    end else begin
      sclk_p_r <= sclk_i;
    end
  end

  // --------------------------------------------------------------
  // bit counter and shifter
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || cs_n_i || !ser_en_i) begin
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      flag_r <= 1'b0;
    end else if (sclk_rise) begin
      if (nine_bit_i && cnt_r == 4'h0) begin
        flag_r <= sdi_i;
      end else begin
        shift_r <= {shift_r[6:0], sdi_i};
      end
      cnt_r <= (cnt_r == last) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // --------------------------------------------------------------
  // byte out
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      byte_o.valid <= 1'b0;
      byte_o.is_data <= 1'b0;
      byte_o.data <= 8'h00;
    end else begin
      byte_o.valid <= ser_en_i && !cs_n_i && sclk_rise && cnt_r == last;
      if (ser_en_i && !cs_n_i && sclk_rise && cnt_r == last) begin
        byte_o.data <= {shift_r[6:0], sdi_i};
        byte_o.is_data <= nine_bit_i ? flag_r : cds_i;
      end
    end
  end

endmodule
`default_nettype wire

// ### ldh_host_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_host_port_props (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic bus_select_pin_a_i,
  input wire logic bus_select_pin_b_i,
  input wire logic bus_select_pin_c_i,
  input wire logic cs_n_i,
  input wire logic [1:0] data_oe_o,
  input wire logic mem_rd_o,
  input wire logic mem_wr_o,
  input wire logic [7:0] cmd_o,
  input wire logic cmd_valid_o,
  input wire logic param_valid_o,
  input wire logic sleep_indicator_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // port checks
  // ----
  a_deselect_float: assert property (cs_n_i [*6] |-> data_oe_o == 2'h0)
    else $error("bus driven while deselected");
  a_select_oe: assert property ($rose(data_oe_o[0]) |-> $past(!cs_n_i, 4))
    else $error("read drive without select");
  a_serial_noread: assert property ((!bus_select_pin_a_i && !bus_select_pin_b_i) [*4] |-> data_oe_o == 2'h0)
    else $error("serial mode drove the bus");
  a_narrow_upper: assert property ((bus_select_pin_b_i && (bus_select_pin_a_i ^ bus_select_pin_c_i)) [*4]
    |-> !data_oe_o[1])
    else $error("upper byte driven in narrow mode");
  a_event_excl: assert property (cmd_valid_o |-> !param_valid_o && !mem_wr_o)
    else $error("command overlaps data event");
  a_pixel_cmd: assert property (mem_wr_o |-> cmd_o == ldh_pkg::CMD_MEM_WRITE)
    else $error("pixel write outside memory write");
  a_param_cmd: assert property (param_valid_o |-> cmd_o != ldh_pkg::CMD_MEM_WRITE)
    else $error("parameter during memory write");
  a_read_fetch: assert property (mem_rd_o |-> data_oe_o[0] ##1 !mem_rd_o)
    else $error("fetch not tied to read");
  a_sleep_enter: assert property (cmd_valid_o && cmd_o == ldh_pkg::CMD_SLEEP_IN
    |-> ##[0:2] !sleep_indicator_n_o)
    else $error("sleep indicator stayed high");
  a_sleep_cause: assert property ($fell(sleep_indicator_n_o) |-> cmd_o == ldh_pkg::CMD_SLEEP_IN)
    else $error("sleep indicator fell without command");
  c_pixel: cover property (mem_wr_o);
  c_fetch: cover property (mem_rd_o);
  c_sleep: cover property ($fell(sleep_indicator_n_o));
endmodule
bind ldh_host_port ldh_host_port_props ldh_host_port_props_i (.ref_clk_i, .sys_rst_i, .bus_select_pin_a_i,
  .bus_select_pin_b_i, .bus_select_pin_c_i, .cs_n_i, .data_oe_o, .mem_rd_o, .mem_wr_o, .cmd_o, .cmd_valid_o,
  .param_valid_o, .sleep_indicator_n_o);
`default_nettype wire

// ### ldh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_host_model (
  input wire logic ref_clk_i,
  input wire logic m68_i,
  input wire logic [15:0] bus_i,
  output logic cs_n_o,
  output logic cds_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] dat_o,
  output logic sdi_o,
  output logic sclk_o
);
  // ----
  // host cycles
  // ----
  initial begin
    cds_o = 1'b0;
    dat_o = 16'h0000;
    sdi_o = 1'b0;
    idle();
  end
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic idle();
    cs_n_o = 1'b1;
    rd_o = !m68_i;
    wr_o = 1'b1;
    sclk_o = 1'b0;
  endtask
  task automatic xfer(input logic sel, input logic rd, input logic cds, input logic [15:0] d, output logic [15:0] q);
    cs_n_o = !sel;
    cds_o = cds;
    wr_o = !m68_i || rd;
    if (!rd) dat_o = d;
    wt(4);
    if (m68_i) rd_o = 1'b1;
    else if (rd) rd_o = 1'b0;
    else wr_o = 1'b0;
    wt(6);
    q = bus_i;
    rd_o = !m68_i;
    if (!m68_i) wr_o = 1'b1;
    wt(4);
    wr_o = 1'b1;
    cs_n_o = 1'b1;
    dat_o = ~dat_o;
    wt(4);
  endtask
  task automatic ser(input logic nine, input logic cds, input logic [7:0] b, input int nb);
    cs_n_o = 1'b0;
    if (!nine) cds_o = cds;
    wt(3);
    for (int i = nine ? -1 : 0; i < nb; i++) begin
      sdi_o = (i < 0) ? cds : b[7 - i];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    sdi_o = ~sdi_o;
    wt(4);
    cs_n_o = 1'b1;
    wt(6);
  endtask
endmodule
`default_nettype wire

// ### ldh_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ldh_host_port_bench;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] strap = 3'h7;
  logic m68 = 1'b0;
  logic [15:0] rdata = 16'h0000;
  logic cs_n, cds, rd, wr, sdi, sclk, ser, n8;
  logic mem_rd, mem_wr, two, cmdv, parv, sleep_n;
  logic [1:0] oe;
  logic [7:0] cmd, par;
  logic [11:0] pix0, pix1;
  logic [15:0] hdat, bus, dout, q;
  int n_fail = 0;
  int tests_run = 0;
  int n_wr = 0;
  int n_ev = 0;
  int n_rd = 0;
  localparam logic [15:0] STAT = 16'h5AC3;
  localparam logic [2:0] MD [4] = '{3'h7, 3'h6, 3'h4, 3'h3};
  // ----
  // clock, bus and instances
  // ----
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  assign ser = strap[2:1] == 2'b00;
  assign n8 = ser || strap == 3'h6 || strap == 3'h3;
  assign bus[15:8] = oe[1] ? dout[15:8] : (n8 ? 8'h00 : hdat[15:8]);
  assign bus[7:0] = oe[0] ? dout[7:0] : (ser ? 8'h00 : hdat[7:0]);
  always @(posedge ref_clk_i) begin
    if (!sys_rst_i) begin
      n_wr += int'(mem_wr);
      n_rd += int'(mem_rd);
      n_ev += int'(cmdv) + int'(parv) + int'(mem_wr) + int'(mem_rd) + int'(|oe);
    end
  end
  ldh_host_model ldh_host_model_i (.ref_clk_i, .m68_i(m68), .bus_i(bus), .cs_n_o(cs_n), .cds_o(cds), .rd_o(rd),
    .wr_o(wr), .dat_o(hdat), .sdi_o(sdi), .sclk_o(sclk));
  ldh_host_port ldh_host_port_i (.ref_clk_i, .sys_rst_i, .bus_select_pin_a_i(strap[2]),
    .bus_select_pin_b_i(strap[1]), .bus_select_pin_c_i(strap[0]), .cs_n_i(cs_n), .cmd_data_select_i(cds),
    .rd_e_i(rd), .wr_rw_i(wr), .data_i(bus), .data_o(dout), .data_oe_o(oe), .sdi_i(sdi), .sclk_i(sclk),
    .status_i(STAT), .mem_rdata_i(rdata), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_two_o(two),
    .mem_pix0_o(pix0), .mem_pix1_o(pix1), .cmd_o(cmd), .cmd_valid_o(cmdv), .param_o(par),
    .param_valid_o(parv), .sleep_indicator_n_o(sleep_n));
  // ----
  // tasks
  // ----
  function automatic logic [3:0] pv(input int n);
    return 4'(n * 7 + 3);
  endfunction
  function automatic logic [11:0] pe(input logic [7:0] b);
    return {pv(int'(b[7:5])), pv(8 + int'(b[4:2])), pv(16 + int'(b[1:0]))};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic tx(input logic s, input logic [15:0] d);
    if (ser) ldh_host_model_i.ser(1'b0, s, d[7:0], 8);
    else ldh_host_model_i.xfer(1'b1, 1'b0, s, d, q);
  endtask
  task automatic r(input logic s);
    ldh_host_model_i.xfer(1'b1, 1'b1, s, 16'h0000, q);
  endtask
  task automatic dc(input logic [2:0] t);
    tx(1'b0, 16'(ldh_pkg::CMD_DATA_CTRL));
    for (int i = 0; i < 3; i++) tx(1'b1, (i == 2) ? 16'(t) : 16'h0000);
  endtask
  task automatic rst(input logic [2:0] s, input logic m);
    sys_rst_i = 1'b1;
    strap = s;
    m68 = m;
    ldh_host_model_i.wt(2);
    ldh_host_model_i.idle();
    sys_rst_i = 1'b0;
    ldh_host_model_i.wt(5);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    int b;
    for (int i = 0; i < 4; i++) begin
      rst(MD[i], i > 1);
      tx(1'b0, 16'(ldh_pkg::CMD_SLEEP_IN));
      chk("cmd", 16'(ldh_pkg::CMD_SLEEP_IN), 16'(cmd));
      chk("sleep", 16'h0000, 16'(sleep_n));
      r(1'b0);
      chk("status", i[0] ? STAT & 16'h00FF : STAT, i[0] ? q & 16'h00FF : q);
      $display("test bus mode %0d done", i);
    end
    dc(ldh_pkg::COLOR_CODE_A);
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_WRITE));
    b = n_wr;
    tx(1'b1, 16'h0012);
    tx(1'b1, 16'h0034);
    chk("early write", 16'(b), 16'(n_wr));
    tx(1'b1, 16'h0056);
    chk("pix0", 16'h0123, 16'(pix0));
    chk("pix1", 16'h0456, 16'(pix1));
    chk("two", 16'h0001, 16'(two));
    chk("writes", 16'(b + 1), 16'(n_wr));
    $display("test gather done");
    rst(3'h7, 1'b0);
    b = n_ev;
    ldh_host_model_i.xfer(1'b0, 1'b0, 1'b0, 16'(ldh_pkg::CMD_SLEEP_IN), q);
    ldh_host_model_i.xfer(1'b0, 1'b1, 1'b1, 16'h0000, q);
    chk("ignored", 16'(b), 16'(n_ev));
    tx(1'b0, 16'(ldh_pkg::CMD_PALETTE_SET));
    for (int i = 0; i < 20; i++) tx(1'b1, {12'h00F, pv(i)});
    chk("param", 16'({4'hF, pv(19)}), 16'(par));
    chk("events", 16'(b + 21), 16'(n_ev));
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_WRITE));
    b = n_wr;
    tx(1'b1, 16'hB74D);
    chk("pix0", 16'(pe(8'hB7)), 16'(pix0));
    chk("pix1", 16'(pe(8'h4D)), 16'(pix1));
    chk("two", 16'h0001, 16'(two));
    chk("writes", 16'(b + 1), 16'(n_wr));
    dc(ldh_pkg::COLOR_CODE_A);
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_WRITE));
    tx(1'b1, 16'hABC7);
    chk("pix0", 16'h0ABC, 16'(pix0));
    dc(ldh_pkg::COLOR_CODE_B);
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_WRITE));
    tx(1'b1, 16'h9DEF);
    chk("pix0", 16'h0DEF, 16'(pix0));
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_READ));
    b = n_rd;
    rdata = 16'h1357;
    r(1'b1);
    rdata = 16'h2468;
    r(1'b1);
    chk("read", 16'h1357, q);
    chk("fetches", 16'(b + 2), 16'(n_rd));
    $display("test pixel formats done");
    rst(3'h0, 1'b0);
    b = n_ev;
    r(1'b1);
    chk("serial read", 16'(b), 16'(n_ev));
    dc(ldh_pkg::COLOR_CODE_B);
    tx(1'b0, 16'(ldh_pkg::CMD_MEM_WRITE));
    ldh_host_model_i.ser(1'b0, 1'b1, 8'h25, 5);
    b = n_wr;
    tx(1'b1, 16'h0025);
    tx(1'b1, 16'h006A);
    chk("pix0", 16'h056A, 16'(pix0));
    chk("two", 16'h0000, 16'(two));
    chk("writes", 16'(b + 1), 16'(n_wr));
    rst(3'h1, 1'b0);
    ldh_host_model_i.ser(1'b1, 1'b0, ldh_pkg::CMD_SLEEP_IN, 8);
    chk("sleep", 16'h0000, 16'(sleep_n));
    ldh_host_model_i.ser(1'b1, 1'b1, 8'h3C, 8);
    chk("param", 16'h003C, 16'(par));
    chk("cmd", 16'(ldh_pkg::CMD_SLEEP_IN), 16'(cmd));
    $display("test serial done");
    end_sim();
  end
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
